// >>> rx_clk_pkg.sv
// Constants, register map and state type for the receiver clock and
// polling core. Assumes a 32-bit classic Wishbone register bus.
package rx_clk_pkg;
  // Crystal divider ratios for frequency plan low and high
  localparam logic [3:0] DIV_LOW = 4'hA;
  localparam logic [3:0] DIV_HIGH = 4'hE;
  // Register byte addresses
  localparam logic [7:0] CFG_ADDR = 8'h00;
  localparam logic [7:0] LIM_ADDR = 8'h04;
  localparam logic [7:0] STAT_ADDR = 8'h08;
  // Operating configuration register fields
  localparam int BAUD_LSB = 0;
  localparam int SLEEP_LSB = 2;
  localparam int XSTD_BIT = 7;
  localparam int XTMP_BIT = 8;
  localparam int NBC_LSB = 9;
  localparam int SINGLE_BIT = 11;
  localparam logic [31:0] CFG_MASK = 32'h00000FFF;
  localparam logic [31:0] CFG_RST = 32'h00000230;
  // Limit register fields
  localparam int LMIN_LSB = 0;
  localparam int LMAX_LSB = 8;
  localparam logic [31:0] LIM_MASK = 32'h00003F3F;
  localparam logic [31:0] LIM_RST = 32'h0000180E;
  // Status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_ASK_BIT = 2;
  localparam int ST_FSKERR_BIT = 3;
  localparam int ST_PLAN_BIT = 4;
  // Polling constants
  localparam logic [4:0] SLEEP_PERM = 5'h1F;
  localparam logic [3:0] XSLEEP_EXT = 4'h8;
  localparam logic [3:0] XSLEEP_STD = 4'h1;
  localparam logic [9:0] SLEEP_PAD = 10'h000;
  localparam logic [4:0] EDGES_PER_STEP = 5'h06;
  localparam logic [7:0] STARTUP_XCLK = 8'h10;
  localparam logic [1:0] FSK_MAX_BAUD = 2'h1;
  // Range clock reload values, one less than the divide ratio
  localparam logic [2:0] RANGE_RL0 = 3'h7;
  localparam logic [2:0] RANGE_RL1 = 3'h3;
  localparam logic [2:0] RANGE_RL2 = 3'h1;
  localparam logic [2:0] RANGE_RL3 = 3'h0;
  // Polling state machine
  typedef enum logic [1:0] {
    ST_SLEEP, ST_STARTUP, ST_BITCHECK, ST_RECEIVE
  } poll_state_t;
endpackage

// >>> receiver_clock_and_poll_control.sv
// Base clock divider, range clock, polling and bit check core of a UHF
// receiver, with a classic Wishbone slave for its registers.
// Assumes all pins except clk_in, srst_in and the Wishbone bus are asynchronous to clk_in.
// Functional notes
// R1: Mode pin low gives FSK, high ASK
// R2: Host uses only two slowest ranges in FSK
// R3: Low-pass corner follows programmed baud range
// R4: Polling powers path briefly for bit check
// R5: Stay active, pass data only after pass
// R6: Polling parameters programmable and applied
// R7: One shared line or separate lines
// R8: Base period from crystal via plan divider
// R9: Base period times polling and processing
// R10: Plan low, 4.90625 MHz gives 2.0383 us
// R11: Plan high, 6.76438 MHz gives 2.0697 us
// R12: Range clock is 8,4,2,1 base periods
// R13: Baud range held in two config bits
// R14: Sleep is value times factor times 1024
// R15: Divider ratio 10 low, 14 high
// R16: Range tick counter reloads on range change
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module receiver_clock_and_poll_control (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic xtal_in,
  input wire logic freq_plan_in,
  input wire logic modulation_select_pin_in,
  input wire logic demod_data_in,
  input wire logic host_stop_in,
  input wire logic line_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic base_tick_out,
  output logic range_tick_out,
  output logic ask_mode_out,
  output logic [1:0] lowpass_sel_out,
  output logic signal_path_en_out,
  output logic data_out,
  output logic line_out,
  output logic line_oe_n_out
);
  // Synchroniser bit positions
  localparam int SX = 0;
  localparam int SP = 1;
  localparam int SM = 2;
  localparam int SD = 3;
  localparam int SH = 4;
  localparam int SL = 5;
  // Idle pin levels after reset: shared line and data high
  localparam logic [5:0] SYNC_IDLE = 6'h28;

  logic [5:0] pins; // Raw asynchronous pins
  logic [5:0] s1_reg; // First synchroniser stage
  logic [5:0] s2_reg; // Second synchroniser stage
  logic xtal_d_reg; // Delayed crystal level
  logic dem_d_reg; // Delayed demodulator level
  logic [3:0] div_cnt_reg; // Crystal divider count
  logic [2:0] range_cnt_reg; // Range tick count
  logic [1:0] baud_d_reg; // Baud range seen last cycle
  logic [31:0] cfg_reg; // Operating configuration register
  logic [31:0] lim_reg; // Bit check limit register
  logic [31:0] rdat_reg; // Read data
  logic ack_reg; // Bus acknowledge
  logic data_reg; // Data to host
  logic oe_n_reg; // Shared line enable, low drives
  logic path_reg; // Signal path enable
  logic ask_reg; // Demodulator mode
  logic [1:0] lp_reg; // Low-pass corner select
  rx_clk_pkg::poll_state_t state_reg, state_next;
  logic [17:0] sleep_cnt_reg; // Base ticks left in sleep
  logic [7:0] su_cnt_reg; // Range ticks spent in start-up
  logic [5:0] tee_cnt_reg; // Range ticks since last edge
  logic [4:0] chk_cnt_reg; // Good edge checks so far
  logic first_reg; // No edge seen yet in bit check
  logic [2:0] oe_hist_reg; // Recent shared line enables

  // Field views of the registers
  logic [1:0] baud;
  logic [4:0] sleep_val;
  logic [1:0] nbc;
  logic single_line;
  logic [5:0] lim_min, lim_max;
  logic xedge, base_tick, range_tick, dem_edge;
  logic [3:0] xf;
  logic [7:0] sx;
  logic [17:0] sleep_len;
  logic [4:0] needed;
  logic early, late, bc_fail, bc_good, bc_pass, stop_req;
  logic wr, rd, enter;

  // Merge write data into a register by byte lane
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Range reload value for a baud range
  function automatic logic [2:0] range_reload(input logic [1:0] b);
    logic [2:0] r;
    r = rx_clk_pkg::RANGE_RL3;
    case (b)
      2'h0: r = rx_clk_pkg::RANGE_RL0;
      2'h1: r = rx_clk_pkg::RANGE_RL1;
      2'h2: r = rx_clk_pkg::RANGE_RL2;
      default: r = rx_clk_pkg::RANGE_RL3;
    endcase
    return r;
  endfunction

  assign pins = {line_in, host_stop_in, demod_data_in,
    modulation_select_pin_in, freq_plan_in, xtal_in};

  // Two-stage synchroniser for every asynchronous pin
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s1_reg <= SYNC_IDLE;
      s2_reg <= SYNC_IDLE;
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
    end
  end

  // Field decode
  assign baud = cfg_reg[rx_clk_pkg::BAUD_LSB +: 2]; // see R13
  assign sleep_val = cfg_reg[rx_clk_pkg::SLEEP_LSB +: 5];
  assign nbc = cfg_reg[rx_clk_pkg::NBC_LSB +: 2];
  assign single_line = cfg_reg[rx_clk_pkg::SINGLE_BIT];
  assign lim_min = lim_reg[rx_clk_pkg::LMIN_LSB +: 6];
  assign lim_max = lim_reg[rx_clk_pkg::LMAX_LSB +: 6];

  // Edge detectors on synchronised levels
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      xtal_d_reg <= 1'b0;
      dem_d_reg <= 1'b1;
    end else begin
      xtal_d_reg <= s2_reg[SX];
      dem_d_reg <= s2_reg[SD];
    end
  end
  assign xedge = s2_reg[SX] & ~xtal_d_reg;
  assign dem_edge = s2_reg[SD] ^ dem_d_reg;

  // Crystal divider, ratio chosen by the plan pin
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      div_cnt_reg <= 4'h0;
    end else if (base_tick) begin
      div_cnt_reg <= 4'h0;
    end else if (xedge) begin
      div_cnt_reg <= div_cnt_reg + 4'h1; // see R10, R11
    end
  end
  // Tick on the last crystal edge of each base period
  assign base_tick = xedge && (div_cnt_reg == ((s2_reg[SP] ? // see R8, R15
    rx_clk_pkg::DIV_HIGH : rx_clk_pkg::DIV_LOW) - 4'h1)); // see R10, R11

  // Range clock counter, restarted on range change
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      range_cnt_reg <= 3'h0;
      baud_d_reg <= 2'h0;
    end else begin
      baud_d_reg <= baud;
      if (baud != baud_d_reg) begin
        range_cnt_reg <= 3'h0; // see R16
      end else if (base_tick) begin
        range_cnt_reg <= (range_cnt_reg == 3'h0) ?
          range_reload(baud) : range_cnt_reg - 3'h1; // see R12
      end
    end
  end
  assign range_tick = base_tick && (range_cnt_reg == 3'h0) &&
    (baud == baud_d_reg);

  // Sleep length from value and extension factor
  assign xf = (cfg_reg[rx_clk_pkg::XSTD_BIT] ||
    cfg_reg[rx_clk_pkg::XTMP_BIT]) ? rx_clk_pkg::XSLEEP_EXT :
    rx_clk_pkg::XSLEEP_STD;
  assign sx = 8'(sleep_val) * 8'(xf);
  assign sleep_len = {sx, rx_clk_pkg::SLEEP_PAD}; // see R14
  assign needed = 5'(nbc * rx_clk_pkg::EDGES_PER_STEP); // see R6

  // Bit check window tests, in range ticks
  assign late = tee_cnt_reg >= lim_max;
  assign early = !first_reg && (tee_cnt_reg < lim_min);
  assign bc_fail = (state_reg == rx_clk_pkg::ST_BITCHECK) &&
    ((dem_edge && early) || late); // see R4
  assign bc_good = (state_reg == rx_clk_pkg::ST_BITCHECK) &&
    dem_edge && !first_reg && !bc_fail;
  assign bc_pass = bc_good && (chk_cnt_reg + 5'h01 == needed);

  // Host stop: own pin, or line pulled low while released
  assign stop_req = single_line ? (!s2_reg[SL] && oe_n_reg &&
    (&oe_hist_reg) && s2_reg[SD]) : s2_reg[SH]; // see R7

  // Line enable history; the read-back pin lags a release by its
  // synchroniser, so a low line only counts after a settled release
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      oe_hist_reg <= 3'h7;
    end else begin
      oe_hist_reg <= {oe_hist_reg[1:0], oe_n_reg};
    end
  end

  // Next polling state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rx_clk_pkg::ST_SLEEP: begin
        if (sleep_val != rx_clk_pkg::SLEEP_PERM &&
            sleep_cnt_reg == 18'h00000) begin
          state_next = rx_clk_pkg::ST_STARTUP;
        end
      end
      rx_clk_pkg::ST_STARTUP: begin
        if (su_cnt_reg >= rx_clk_pkg::STARTUP_XCLK) begin
          state_next = (needed == 5'h00) ?
            rx_clk_pkg::ST_RECEIVE : rx_clk_pkg::ST_BITCHECK;
        end
      end
      rx_clk_pkg::ST_BITCHECK: begin
        if (bc_fail) begin
          state_next = rx_clk_pkg::ST_SLEEP; // see R5
        end else if (bc_pass) begin
          state_next = rx_clk_pkg::ST_RECEIVE; // see R5
        end
      end
      default: begin
        if (stop_req) begin
          state_next = rx_clk_pkg::ST_SLEEP;
        end
      end
    endcase
  end
  assign enter = state_next != state_reg;

  // Polling state register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= rx_clk_pkg::ST_SLEEP;
    end else begin
      state_reg <= state_next;
    end
  end

  // Sleep counter in base periods
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sleep_cnt_reg <= 18'h00000;
    end else if (enter && state_next == rx_clk_pkg::ST_SLEEP) begin
      sleep_cnt_reg <= sleep_len; // see R14, R9
    end else if (base_tick && sleep_cnt_reg != 18'h00000) begin
      sleep_cnt_reg <= sleep_cnt_reg - 18'h00001;
    end
  end

  // Start-up counter in range periods
  always_ff @(posedge clk_in) begin
    if (srst_in || enter) begin
      su_cnt_reg <= 8'h00;
    end else if (range_tick && state_reg == rx_clk_pkg::ST_STARTUP) begin
      su_cnt_reg <= su_cnt_reg + 8'h01;
    end
  end

  // Edge-to-edge timer and check counter
  always_ff @(posedge clk_in) begin
    if (srst_in || enter) begin
      tee_cnt_reg <= 6'h00;
      chk_cnt_reg <= 5'h00;
      first_reg <= 1'b1;
    end else if (state_reg == rx_clk_pkg::ST_BITCHECK) begin
      if (dem_edge) begin
        tee_cnt_reg <= 6'h00;
        first_reg <= 1'b0;
      end else if (range_tick && tee_cnt_reg != 6'h3F) begin
        tee_cnt_reg <= tee_cnt_reg + 6'h01; // see R9
      end
      if (bc_good) begin
        chk_cnt_reg <= chk_cnt_reg + 5'h01;
      end
    end
  end

  // Wishbone strobes; writes land on the acknowledged edge
  assign rd = wb_cyc_in && wb_stb_in && !ack_reg;
  assign wr = wb_cyc_in && wb_stb_in && wb_we_in && ack_reg;

  // Configuration register; failed check drops temporary extension
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cfg_reg <= rx_clk_pkg::CFG_RST;
    end else if (wr && wb_adr_in == rx_clk_pkg::CFG_ADDR) begin
      cfg_reg <= merge(cfg_reg, wb_dat_in, wb_sel_in) &
        rx_clk_pkg::CFG_MASK; // see R6, R3
    end else if (bc_fail) begin
      cfg_reg[rx_clk_pkg::XTMP_BIT] <= 1'b0;
    end
  end

  // Limit register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      lim_reg <= rx_clk_pkg::LIM_RST;
    end else if (wr && wb_adr_in == rx_clk_pkg::LIM_ADDR) begin
      lim_reg <= merge(lim_reg, wb_dat_in, wb_sel_in) &
        rx_clk_pkg::LIM_MASK; // see R6
    end
  end

  // Acknowledge and read data, one cycle after the request
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
    end else begin
      ack_reg <= rd;
      if (rd) begin
        if (wb_adr_in == rx_clk_pkg::CFG_ADDR) begin
          rdat_reg <= cfg_reg;
        end else if (wb_adr_in == rx_clk_pkg::LIM_ADDR) begin
          rdat_reg <= lim_reg;
        end else if (wb_adr_in == rx_clk_pkg::STAT_ADDR) begin
          rdat_reg <= 32'h00000000;
          rdat_reg[rx_clk_pkg::ST_STATE_LSB +: 2] <= state_reg;
          rdat_reg[rx_clk_pkg::ST_ASK_BIT] <= ask_reg;
          rdat_reg[rx_clk_pkg::ST_FSKERR_BIT] <= !ask_reg &&
            (baud > rx_clk_pkg::FSK_MAX_BAUD); // see R2
          rdat_reg[rx_clk_pkg::ST_PLAN_BIT] <= s2_reg[SP];
        end else begin
          rdat_reg <= 32'h00000000;
        end
      end
    end
  end

  // Registered pin outputs
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      data_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      path_reg <= 1'b0;
      ask_reg <= 1'b0;
      lp_reg <= 2'h0;
    end else begin
      data_reg <= (state_next == rx_clk_pkg::ST_RECEIVE) ?
        s2_reg[SD] : 1'b1; // see R5
      oe_n_reg <= !(single_line && !s2_reg[SD] &&
        state_next == rx_clk_pkg::ST_RECEIVE); // see R7
      path_reg <= state_next != rx_clk_pkg::ST_SLEEP; // see R4
      ask_reg <= s2_reg[SM]; // see R1
      lp_reg <= baud; // see R3
    end
  end

  assign wb_ack_out = ack_reg;
  assign wb_dat_out = rdat_reg;
  assign base_tick_out = base_tick;
  assign range_tick_out = range_tick;
  assign ask_mode_out = ask_reg;
  assign lowpass_sel_out = lp_reg;
  assign signal_path_en_out = path_reg;
  assign data_out = data_reg;
  assign line_out = 1'b0;
  assign line_oe_n_out = oe_n_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_good_last;
    bc_pass;
  endsequence
  sequence s_in_receive;
    state_reg == rx_clk_pkg::ST_RECEIVE;
  endsequence

  chk_ask_mode: assert property ( // see R1
    ##1 ask_mode_out == $past(s2_reg[SM]))
    else $error("ask mode does not follow pin");
  chk_lowpass_sel: assert property ( // see R3
    ##1 lowpass_sel_out == $past(baud))
    else $error("low-pass select wrong");
  chk_path_sleep: assert property ( // see R4
    state_reg == rx_clk_pkg::ST_SLEEP |-> !signal_path_en_out)
    else $error("signal path on in sleep");
  chk_data_gate: assert property ( // see R5
    state_reg != rx_clk_pkg::ST_RECEIVE |-> data_out)
    else $error("data passed while not receiving");
  chk_pass_receive: assert property ( // see R6
    s_good_last |=> s_in_receive)
    else $error("bit check pass did not enter receive");
  chk_fail_temp: assert property ( // see R14
    bc_fail && !wr |=> !cfg_reg[rx_clk_pkg::XTMP_BIT] &&
    state_reg == rx_clk_pkg::ST_SLEEP)
    else $error("failed check kept extension");
  chk_base_div: assert property ( // see R8
    base_tick_out |-> xedge && $past(s2_reg[SX]) == 1'b0)
    else $error("base tick without crystal edge");
  chk_range_fast: assert property ( // see R12
    baud == 2'h3 && baud_d_reg == 2'h3 && range_cnt_reg == 3'h0
    |-> range_tick_out == base_tick_out)
    else $error("fastest range tick mismatch");
  chk_line_drive: assert property ( // see R7
    !single_line |=> line_oe_n_out)
    else $error("shared line driven in split mode");
endmodule // receiver_clock_and_poll_control
`default_nettype wire

// >>> rx_host_model.sv
// Host side model: crystal pin, demodulator level and shared line.
// Assumes the bench sets the demodulator edge gap; zero holds the level.
`timescale 1ns/100ps
`default_nettype none
module rx_host_model (
  input wire logic drv_in,
  input wire logic oe_n_in,
  input wire logic [15:0] gap_in,
  input wire logic stop_in,
  output logic xtal_out,
  output logic demod_out,
  output logic line_lvl_out,
  output logic stop_out
);
  // Crystal runs free, unrelated in phase to the bench clock
  initial begin
    xtal_out = 1'b0;
    #3;
    forever #10 xtal_out = ~xtal_out;
  end
  // Preburst pattern with a fixed edge gap, or a held level
  initial begin
    demod_out = 1'b1;
    forever begin
      if (gap_in == 16'h0000) begin
        #100;
      end else begin
        #(gap_in);
        demod_out = ~demod_out;
      end
    end
  end
  // Pull-up on the shared line; the device only pulls it low
  assign line_lvl_out = oe_n_in ? 1'b1 : drv_in;
  // Stop request pin, level set by the bench
  assign stop_out = stop_in;
endmodule // rx_host_model
`default_nettype wire

// >>> test_receiver_clock_and_poll_control.sv
// Self-checking bench for the receiver clock and polling core.
// Assumes the host model supplies crystal, demodulator and line levels.
`timescale 1ns/100ps
`default_nettype none
module test_receiver_clock_and_poll_control;
  logic clk, srst, plan, msel, cyc, stb, we; // Bench driven inputs
  logic [7:0] adr;
  logic [31:0] wdat, rdat, r;
  logic [3:0] sel;
  logic ack, btick, rtick, ask, path, dout, lout, loe_n;
  logic [1:0] lp;
  logic xtal, dem, lin, stop; // Host model outputs
  logic stop_rq; // Host stop request level
  logic [15:0] gap; // Demodulator edge gap in ns
  logic [31:0] exp_q[$]; // Expected read words, oldest first
  int error_cnt, n_checks, c;

  receiver_clock_and_poll_control dut_u (.clk_in(clk), .srst_in(srst),
    .xtal_in(xtal), .freq_plan_in(plan), .modulation_select_pin_in(msel),
    .demod_data_in(dem), .host_stop_in(stop), .line_in(lin),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_dat_in(wdat), .wb_sel_in(sel), .wb_dat_out(rdat), .wb_ack_out(ack),
    .base_tick_out(btick), .range_tick_out(rtick), .ask_mode_out(ask),
    .lowpass_sel_out(lp), .signal_path_en_out(path), .data_out(dout),
    .line_out(lout), .line_oe_n_out(loe_n));
  rx_host_model host_u (.drv_in(lout), .oe_n_in(loe_n), .gap_in(gap),
    .stop_in(stop_rq),
    .xtal_out(xtal), .demod_out(dem), .line_lvl_out(lin), .stop_out(stop));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Word compare, shared by all result kinds
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // Count compare
  task automatic cmp_count(input int g, input int e);
    cmp_word(32'(g), 32'(e));
  endtask
  // Pin level compare
  task automatic cmp_pin(input logic g, input logic e);
    cmp_word({31'h0, g}, {31'h0, e});
  endtask
  // One classic Wishbone cycle, held until ack is sampled high
  task automatic xfer(input logic [7:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] v);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n >= 100) error_cnt++;
    v = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    xfer(a, 1'b1, d, v);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    xfer(a, 1'b0, 32'h00000000, v);
  endtask
  // Read whose word the monitor checks
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    exp_q.push_back(e);
    rd(a, v);
  endtask
  // Monitor: each read answer given while a note waits is matched to the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      cmp_word(rdat, exp_q.pop_front());
    end
  end
  // Wait for base tick, range tick, path up or path down
  task automatic wait_for(input int s);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!((s == 0 && btick === 1'b1) || (s == 1 && rtick === 1'b1)
      || (s == 2 && path === 1'b1) || (s == 3 && path === 1'b0))
      && n < 60000);
    if (n >= 60000) error_cnt++;
  endtask
  // Base ticks until the next range tick or until the path wakes
  task automatic count_base(input int s, output int k);
    k = 0;
    do begin
      @(posedge clk);
      if (btick === 1'b1) k++;
    end while (!((s == 1 && rtick === 1'b1) || (s == 2 && path === 1'b1))
      && k < 2000);
  endtask
  // Crystal rising edges between two base ticks
  task automatic count_xtal(output int k);
    logic p;
    wait_for(0);
    k = 0;
    p = xtal;
    do begin
      @(posedge clk);
      if (xtal === 1'b1 && p === 1'b0) k++;
      p = xtal;
    end while (btick !== 1'b1 && k < 100);
  endtask
  // Verdict and end of run
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    finish_test;
  end
  // Main sequence
  initial begin
    srst = 1'b1;
    plan = 1'b0;
    msel = 1'b1;
    stop_rq = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h00000000;
    sel = 4'h0;
    gap = 16'h0000;
    error_cnt = 0;
    n_checks = 0;
    void'($urandom(2698));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd_chk(8'h00, 32'h00000230);
    wr(8'h00, 32'h00000200);
    rd_chk(8'h04, 32'h0000180E);
    r = $urandom & rx_clk_pkg::LIM_MASK;
    wr(8'h04, r);
    rd_chk(8'h04, r);
    wr(8'h04, rx_clk_pkg::LIM_RST);
    wr(8'h0C, $urandom);
    rd_chk(8'h0C, 32'h00000000);
    // Every baud range: low-pass select and range clock ratio
    for (int b = 0; b < 4; b++) begin
      wr(8'h00, 32'h00000200 | 32'(b));
      repeat (3) @(posedge clk);
      cmp_word({30'h0, lp}, 32'(b));
      wait_for(1);
      count_base(1, c);
      cmp_count(c, 8 >> b);
    end
    // Both frequency plans
    for (int p = 0; p < 2; p++) begin
      plan <= p[0];
      repeat (60) @(posedge clk);
      count_xtal(c);
      cmp_count(c, p ? 14 : 10);
    end
    plan <= 1'b0;
    // Both demodulator modes; FSK only with a slow range
    wr(8'h00, 32'h00000201);
    for (int m = 0; m < 2; m++) begin
      msel <= m[0];
      repeat (5) @(posedge clk);
      cmp_pin(ask, m[0]);
      rd(8'h08, r);
      cmp_word(r & 32'h0000001C, 32'(m) << 2);
    end
    // Failed check clears the temporary extension
    wr(8'h00, 32'h00000303);
    c = 0;
    do begin
      rd(8'h00, r);
      c++;
    end while (r[8] === 1'b1 && c < 2000);
    cmp_word(r, 32'h00000203);
    // Sleep of one unit lasts 1024 base ticks
    wr(8'h00, 32'h00000207);
    wait_for(3);
    count_base(2, c);
    cmp_count((c >= 1023 && c <= 1025) ? 1024 : c, 1024);
    // Valid preburst leads to receive with the signal path on
    gap <= 16'h0E10;
    wr(8'h00, 32'h00000203);
    c = 0;
    do begin
      repeat (20) @(posedge clk);
      rd(8'h08, r);
      c++;
    end while (r[1:0] !== 2'h3 && c < 1000);
    cmp_pin(path, 1'b1);
    cmp_word({30'h0, r[1:0]}, 32'h00000003);
    // Single shared line: the device pulls the line with the data
    wr(8'h00, 32'h00000A03);
    for (int i = 0; i < 3; i++) begin
      @(dem);
      repeat (10) @(posedge clk);
      cmp_pin(dout, dem);
      cmp_pin(lin, dem);
    end
    // Host stop from receive into a permanent sleep
    wr(8'h00, 32'h0000027F);
    stop_rq <= 1'b1;
    wait_for(3);
    repeat (3000) @(posedge clk);
    cmp_pin(path, 1'b0);
    rd(8'h08, r);
    cmp_word({30'h0, r[1:0]}, 32'h00000000);
    finish_test;
  end
endmodule // test_receiver_clock_and_poll_control
`default_nettype wire
